// file: hsc_halt_standby.sv
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module hsc_halt_standby #(
  parameter int unsigned NUM_IRQ  = 8,
  parameter int unsigned HOLD_CYC = hsc_pkg::HOLD_CYC_DEF
) (
  input  wire  logic                       clock,
  input  wire  logic                       srst,
  input  wire  logic                       clkEn,
  // avalon-mm slave
  input  wire  logic [hsc_pkg::ADDR_W-1:0] address,
  input  wire  logic                       read,
  input  wire  logic                       write,
  input  wire  logic [31:0]                writedata,
  input  wire  logic [3:0]                 byteenable,
  output logic       [31:0]                readdata,
  output logic                             waitrequest,
  // cpu side
  input  wire  logic                       haltExec,
  input  wire  logic [NUM_IRQ-1:0]         irqReq,
  input  wire  logic [NUM_IRQ-1:0]         interruptMaskFlag,
  input  wire  logic                       interruptAcceptFlag,
  input  wire  logic                       resetPin,
  output logic                             cpuClkEn,
  output logic                             cpuHeld,
  output logic                             vectorGo,
  output logic                             resumeGo,
  output logic                             resetVectorGo,
  // peripheral side
  output logic                             periphClkEn,
  output logic                             timerOneRun,
  output logic                             wdtRun,
  output logic                             slowOscRun,
  output logic                             portHold
);
  import hsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  hsc_state_t       stateQ, stateD;
  hsc_ctrl_t        ctrlQ;
  hsc_run_t         runQ, runD;
  logic [WAIT_W-1:0] waitQ, waitD;
  logic [HOLD_W-1:0] holdQ, holdD;
  logic             vectoredQ, vectoredD;
  logic             cpuEnQ;
  logic             vecGoQ, resGoQ, rstGoQ;
  logic             ackQ;
  logic [31:0]      rdataQ;

  ////////////////////////////////////////////////////////////////////////////
  // wake and reset decode
  wire wakeReq  = |(irqReq & ~interruptMaskFlag);
  wire anyReset = srst | resetPin;
  wire waitDone = (waitQ == '0);
  wire holdDone = (holdQ == '0);
  wire haltLike = (stateD == HSC_HALT) || (stateD == HSC_WAKE);

  // wait length chosen by the accept flag at release
  function automatic logic [WAIT_W-1:0] wakeWait(input logic vec);
    wakeWait = vec ? WAIT_W'(VEC_WAIT_CYC - 1) : WAIT_W'(NEXT_WAIT_CYC - 1);
  endfunction : wakeWait

  ////////////////////////////////////////////////////////////////////////////
  // next state; everything sampled on the system clock only
  always_comb begin
    stateD    = stateQ;
    waitD     = waitQ;
    holdD     = holdQ;
    vectoredD = vectoredQ;
    unique case (stateQ)
      HSC_RUN: begin
        if (haltExec) begin
          stateD = HSC_HALT;
        end
      end
      HSC_HALT: begin
        // a request already pending at entry releases on the next edge
        if (wakeReq) begin
          stateD    = HSC_WAKE;
          vectoredD = interruptAcceptFlag;
          waitD     = wakeWait(interruptAcceptFlag);
        end
      end
      HSC_WAKE: begin
        if (waitDone) begin
          stateD = HSC_RUN;
        end else begin
          waitD = waitQ - WAIT_W'(1);
        end
      end
      HSC_RSTHOLD: begin
        if (holdDone) begin
          stateD = HSC_RUN;
        end else begin
          holdD = holdQ - HOLD_W'(1);
        end
      end
    endcase
    // reset input beats any other event, also in halt
    if (anyReset) begin
      stateD    = HSC_RSTHOLD;
      holdD     = HOLD_W'(HOLD_CYC - 1);
      waitD     = '0;
      vectoredD = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // peripheral enables; oscillator itself is never stopped by halt
  wire slowRunD = !(ctrlQ.optStoppable && ctrlQ.slowStopReq);
  wire notRst   = (stateD != HSC_RSTHOLD);
  wire halting  = (stateD == HSC_HALT);
  assign runD.periphClk  = notRst;
  assign runD.slowOscRun = slowRunD;
  assign runD.timerOneRun = notRst &&
                           (ctrlQ.timerOneFromSlow ? slowRunD : 1'b1);
  assign runD.wdtRun     = notRst && (!halting ||
                           (ctrlQ.wdtFromSlow && !ctrlQ.optStoppable));
  assign runD.portHold   = haltLike;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer flops; the cpu gate is its own flop so it cannot glitch
  always_ff @(posedge clock) begin
    if (srst) begin
      stateQ    <= HSC_RSTHOLD;
      holdQ     <= HOLD_W'(HOLD_CYC - 1);
      waitQ     <= '0;
      vectoredQ <= 1'b0;
      cpuEnQ    <= 1'b0;
      runQ      <= RUN_RST;
      vecGoQ    <= 1'b0;
      resGoQ    <= 1'b0;
      rstGoQ    <= 1'b0;
    end else if (clkEn) begin
      stateQ    <= stateD;
      holdQ     <= holdD;
      waitQ     <= waitD;
      vectoredQ <= vectoredD;
      cpuEnQ    <= (stateD == HSC_RUN);
      runQ      <= runD;
      vecGoQ    <= (stateQ == HSC_WAKE) && waitDone && vectoredQ && !anyReset;
      resGoQ    <= (stateQ == HSC_WAKE) && waitDone && !vectoredQ && !anyReset;
      rstGoQ    <= (stateQ == HSC_RSTHOLD) && holdDone && !anyReset;
    end
  end

  assign cpuClkEn      = cpuEnQ;
  assign cpuHeld       = (stateQ == HSC_RSTHOLD);
  assign vectorGo      = vecGoQ;
  assign resumeGo      = resGoQ;
  assign resetVectorGo = rstGoQ;
  assign periphClkEn   = runQ.periphClk;
  assign timerOneRun   = runQ.timerOneRun;
  assign wdtRun        = runQ.wdtRun;
  assign slowOscRun    = runQ.slowOscRun;
  assign portHold      = runQ.portHold;

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait state, write lands on the edge waitrequest is low
  wire       busReq    = read | write;
  wire       ctrlHit   = (address == CTRL_OFFS);
  wire       statHit   = (address == STAT_OFFS);
  wire       writeFire = write && ackQ && ctrlHit && (byteenable & CTRL_BE) != '0;
  hsc_stat_t statNow;
  assign statNow.slowOscRun   = runQ.slowOscRun;
  assign statNow.lastVectored = vectoredQ;
  assign statNow.resetHold    = (stateQ == HSC_RSTHOLD);
  assign statNow.waking       = (stateQ == HSC_WAKE);
  assign statNow.halted       = (stateQ == HSC_HALT);
  wire [31:0] rdMux = ctrlHit ? {{(32-CTRL_W){1'b0}}, ctrlQ}   :
                      statHit ? {{(32-STAT_W){1'b0}}, statNow} : 32'h0000_0000;
  assign waitrequest = busReq && !(ackQ && clkEn);  // a frozen slave never answers
  assign readdata    = rdataQ;

  // control is untouched by halt, so settings survive standby
  always_ff @(posedge clock) begin
    if (srst) begin
      ackQ   <= 1'b0;
      rdataQ <= 32'h0000_0000;
      ctrlQ  <= CTRL_RST;
    end else if (clkEn) begin
      ackQ <= busReq && !ackQ;
      if (read && !ackQ) begin
        rdataQ <= rdMux;
      end
      if (writeFire) begin
        ctrlQ <= hsc_ctrl_t'(writedata[CTRL_W-1:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper counters for the checks below
  logic [WAIT_W-1:0] wakeCycQ;
  logic [HOLD_W-1:0] holdCycQ;
  always_ff @(posedge clock) begin
    if (srst) begin
      wakeCycQ <= '0;
      holdCycQ <= '0;
    end else if (clkEn) begin
      wakeCycQ <= (stateQ == HSC_WAKE) ? wakeCycQ + WAIT_W'(1) : '0;
      holdCycQ <= (stateQ == HSC_RSTHOLD && !anyReset) ? holdCycQ + HOLD_W'(1) : '0;
    end
  end

  halt_entry_a: assert property (@(posedge clock) disable iff (srst)
    (stateQ == HSC_RUN && haltExec && clkEn && !resetPin) |=> (stateQ == HSC_HALT))
    else $error("halt instruction did not enter halt");

  pending_wake_a: assert property (@(posedge clock) disable iff (srst)
    (stateQ == HSC_HALT && wakeReq && clkEn && !resetPin) |=> (stateQ == HSC_WAKE))
    else $error("unmasked request did not release halt");

  cpu_gate_a: assert property (@(posedge clock) disable iff (srst)
    cpuClkEn == (stateQ == HSC_RUN))
    else $error("cpu clock gate disagrees with state");

  port_hold_a: assert property (@(posedge clock) disable iff (srst)
    (stateQ == HSC_HALT) |-> (portHold && periphClkEn))
    else $error("ports or peripherals not held in halt");

  timer_one_slow_a: assert property (@(posedge clock) disable iff (srst)
    (stateQ == HSC_HALT && ctrlQ.timerOneFromSlow && $stable(ctrlQ))
      |-> (timerOneRun == slowOscRun))
    else $error("timer one does not follow slow oscillator");

  wdt_periph_a: assert property (@(posedge clock) disable iff (srst)
    (stateQ == HSC_HALT && !ctrlQ.wdtFromSlow && $stable(ctrlQ)) |-> !wdtRun)
    else $error("watchdog on peripheral clock runs in halt");

  wdt_slow_a: assert property (@(posedge clock) disable iff (srst)
    (stateQ == HSC_HALT && ctrlQ.wdtFromSlow && $stable(ctrlQ))
      |-> (wdtRun == !ctrlQ.optStoppable))
    else $error("watchdog on slow clock wrong in halt");

  masked_hold_a: assert property (@(posedge clock) disable iff (srst)
    (stateQ == HSC_HALT && !wakeReq && !resetPin) |=> (stateQ == HSC_HALT))
    else $error("halt left without unmasked request");

  vec_wait_a: assert property (@(posedge clock) disable iff (srst)
    (stateQ == HSC_WAKE && waitDone && clkEn && !resetPin) |->
      (wakeCycQ == (vectoredQ ? WAIT_W'(VEC_WAIT_CYC - 1) : WAIT_W'(NEXT_WAIT_CYC - 1))))
    else $error("wake wait length wrong");

  wake_kind_a: assert property (@(posedge clock) disable iff (srst)
    (stateQ == HSC_WAKE && waitDone && clkEn && !resetPin) |=>
      (vectorGo == vectoredQ && resumeGo == !vectoredQ && stateQ == HSC_RUN))
    else $error("wake did not vector or resume correctly");

  reset_exit_a: assert property (@(posedge clock) disable iff (srst)
    (resetPin && clkEn) |=> (stateQ == HSC_RSTHOLD && !cpuClkEn ##1 !cpuClkEn))
    else $error("reset input did not hold the cpu");

  reset_hold_a: assert property (@(posedge clock) disable iff (srst)
    $rose(resetVectorGo) |-> ($past(holdCycQ) == HOLD_W'(HOLD_CYC - 1)))
    else $error("reset hold length wrong");

endmodule : hsc_halt_standby

// file: hsc_pkg.sv
package hsc_pkg;

  // register map, byte addresses on the Avalon slave
  localparam int unsigned ADDR_W      = 3;
  localparam logic [2:0]  CTRL_OFFS   = 3'h0;
  localparam logic [2:0]  STAT_OFFS   = 3'h4;
  localparam logic [3:0]  CTRL_BE     = 4'h1;

  // control register, low bits of the word
  typedef struct packed {
    logic optStoppable; // bit 3: option lets software stop the slow oscillator
    logic timerOneFromSlow; // bit 2: eight_bit_timer_one counts slow osc / 2^7
    logic wdtFromSlow;  // bit 1: watchdog counts the slow oscillator
    logic slowStopReq;  // bit 0: software stop request for the slow oscillator
  } hsc_ctrl_t;
  localparam int unsigned CTRL_W   = 4;
  localparam hsc_ctrl_t   CTRL_RST = '0;

  // status register, low bits of the word
  typedef struct packed {
    logic slowOscRun;   // bit 4
    logic lastVectored; // bit 3
    logic resetHold;    // bit 2
    logic waking;       // bit 1
    logic halted;       // bit 0
  } hsc_stat_t;
  localparam int unsigned STAT_W = 5;

  // peripheral run enables, registered as one group
  typedef struct packed {
    logic periphClk;
    logic timerOneRun;
    logic wdtRun;
    logic slowOscRun;
    logic portHold;
  } hsc_run_t;
  localparam hsc_run_t RUN_RST = '0;

  typedef enum logic [1:0] {
    HSC_RUN,
    HSC_HALT,
    HSC_WAKE,
    HSC_RSTHOLD
  } hsc_state_t;

  // wake-up waits in cpu clocks
  localparam int unsigned VEC_WAIT_CYC  = 9;
  localparam int unsigned NEXT_WAIT_CYC = 1;
  localparam int unsigned WAIT_W        = 4;

  // reset hold: 8 slow periods plus 96 fast periods while the option is read
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned SLOW_PERIOD_PS  = 4166667;
  localparam int unsigned FAST_PERIOD_PS  = 125000;
  localparam int unsigned SLOW_HOLD_N     = 8;
  localparam int unsigned FAST_HOLD_N     = 96;
  localparam longint unsigned HOLD_TIME_PS =
    longint'(SLOW_HOLD_N) * SLOW_PERIOD_PS + longint'(FAST_HOLD_N) * FAST_PERIOD_PS;
  localparam int unsigned HOLD_CYC_DEF =
    int'((HOLD_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned HOLD_W = 16;

endpackage : hsc_pkg

// file: hsc_cpu_model.sv
`timescale 1ns/1ps
module hsc_cpu_model #(
  parameter logic [15:0] RESET_ADDR = 16'h0000,
  parameter logic [15:0] VEC_ADDR   = 16'h0040  // arbitrary service entry
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        cpuClkEn,
  input  wire logic        vectorGo,
  input  wire logic        resumeGo,
  input  wire logic        resetVectorGo,
  output logic      [15:0] pc
);
  logic [15:0] pc_q;

  assign pc = pc_q;

  ////////////////////////////////////////////////////////////////////////
  // fetch pointer steps on an open cpu gate or a resume pulse and jumps on the vector pulses, so a leaky gate shows up
  always_ff @(posedge clock) begin
    if (srst || resetVectorGo) begin
      pc_q <= RESET_ADDR;
    end else if (vectorGo) begin
      pc_q <= VEC_ADDR;
    end else if (cpuClkEn || resumeGo) begin
      pc_q <= pc_q + 16'h0001;
    end
  end
endmodule : hsc_cpu_model

// file: halt_standby_control_test.sv
`timescale 1ns/1ps
module halt_standby_control_test;
  import hsc_pkg::*;
  localparam int unsigned HOLD = 20;  // short hold keeps the run brief
  logic        clock, srst, read, write, haltExec, accept, resetPin, clkEn;
  logic [2:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0]  byteenable;
  logic        waitrequest, cpuClkEn, cpuHeld, vectorGo, resumeGo, resetVectorGo;
  logic        periphClkEn, timerOneRun, wdtRun, slowOscRun, portHold, slow;
  logic [7:0]  irqReq, maskFlag;
  logic [15:0] pc, pcHeld;
  int          errors = 0, nCompared = 0, cycles = 0, n;

  hsc_halt_standby #(.NUM_IRQ(8), .HOLD_CYC(HOLD)) uut (
    .clock(clock), .srst(srst), .clkEn(clkEn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .haltExec(haltExec),
    .irqReq(irqReq), .interruptMaskFlag(maskFlag), .interruptAcceptFlag(accept),
    .resetPin(resetPin), .cpuClkEn(cpuClkEn), .cpuHeld(cpuHeld),
    .vectorGo(vectorGo), .resumeGo(resumeGo), .resetVectorGo(resetVectorGo),
    .periphClkEn(periphClkEn), .timerOneRun(timerOneRun), .wdtRun(wdtRun),
    .slowOscRun(slowOscRun), .portHold(portHold));

  hsc_cpu_model partner (
    .clock(clock), .srst(srst), .cpuClkEn(cpuClkEn), .vectorGo(vectorGo),
    .resumeGo(resumeGo), .resetVectorGo(resetVectorGo), .pc(pc));

  ////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  // one avalon transfer; request held until waitrequest is seen low at a rising edge
  task automatic busAccess(input logic wr, input logic [2:0] addr, input logic [31:0] data);
    @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= addr;
    writedata <= data;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : busAccess

  // counts edges until the chosen pulse: 0 vector, 1 resume, 2 reset vector
  task automatic countTo(input int sel, output int cnt);
    cnt = 0;
    do begin
      @(negedge clock);
      cnt++;
    end while (!(sel == 0 ? vectorGo === 1'b1 : sel == 1 ? resumeGo === 1'b1 :
                 resetVectorGo === 1'b1) && cnt < 20000);
  endtask : countTo

  task automatic wrap_up();
    if (errors == 0 && nCompared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {srst, read, write, haltExec, accept, resetPin} = 6'h20;
    clkEn = 1'b1;
    address = 3'h0;
    writedata = 32'h0;
    byteenable = 4'h1;
    irqReq = 8'h00;
    maskFlag = 8'hff;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    countTo(2, n);
    chk("reset hold", (n >= HOLD && n <= HOLD + 4), 1'b1);
    // register map, control write and readback and an unmapped place
    busAccess(1'b0, CTRL_OFFS, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    busAccess(1'b1, CTRL_OFFS, 32'hffffffff);
    busAccess(1'b0, CTRL_OFFS, 32'h0);
    chk("ctrl", rd, 32'hf);
    busAccess(1'b1, 3'h2, 32'hffffffff);
    busAccess(1'b0, 3'h2, 32'h0);
    chk("unmapped", rd, 32'h0);
    // every control setting, alternating vector and resume release
    for (int c = 0; c < 16; c++) begin
      busAccess(1'b1, CTRL_OFFS, 32'(c));
      @(posedge clock);
      accept <= c[0];
      maskFlag <= 8'hff;
      irqReq <= 8'h01;
      haltExec <= 1'b1;
      @(posedge clock);
      haltExec <= 1'b0;
      @(negedge clock);
      pcHeld = pc;
      repeat (3) @(negedge clock);
      slow = !(c[3] && c[0]);
      chk("cpuClkEn", cpuClkEn, 1'b0);
      chk("pc", pc, pcHeld);
      chk("portHold", portHold, 1'b1);
      chk("periphClkEn", periphClkEn, 1'b1);
      chk("slowOscRun", slowOscRun, slow);
      chk("timerOneRun", timerOneRun, c[2] ? slow : 1'b1);
      chk("wdtRun", wdtRun, c[1] ? !c[3] : 1'b0);
      @(posedge clock);
      maskFlag <= 8'hfe;
      countTo(c[0] ? 0 : 1, n);
      chk("wake", n, c[0] ? VEC_WAIT_CYC + 2 : NEXT_WAIT_CYC + 2);
      @(posedge clock);
      irqReq <= 8'h00;
    end
    // request already pending at entry
    @(posedge clock);
    accept <= 1'b0;
    irqReq <= 8'h01;
    haltExec <= 1'b1;
    @(posedge clock);
    haltExec <= 1'b0;
    countTo(1, n);
    chk("pending", n, NEXT_WAIT_CYC + 2);
    // frozen clock enable keeps halt although a request is already unmasked
    @(posedge clock);
    maskFlag <= 8'hff;
    haltExec <= 1'b1;
    @(posedge clock);
    haltExec <= 1'b0;
    clkEn <= 1'b0;
    maskFlag <= 8'hfe;
    repeat (4) @(negedge clock);
    chk("frozen halt", {cpuClkEn, portHold}, 2'b01);
    @(posedge clock);
    clkEn <= 1'b1;
    countTo(1, n);
    chk("thawed wake", n, NEXT_WAIT_CYC + 2);
    // reset input ends a halt with masked traffic
    @(posedge clock);
    maskFlag <= 8'hff;
    haltExec <= 1'b1;
    @(posedge clock);
    haltExec <= 1'b0;
    busAccess(1'b0, STAT_OFFS, 32'h0);
    chk("status", rd & 32'h7, 32'h1);
    @(posedge clock);
    resetPin <= 1'b1;
    @(posedge clock);
    resetPin <= 1'b0;
    @(negedge clock);
    chk("cpuHeld", cpuHeld, 1'b1);
    countTo(2, n);
    chk("reset release", (n >= HOLD - 1 && n <= HOLD + 4), 1'b1);
    @(negedge clock);
    chk("pc restart", pc, 16'h0000);
    busAccess(1'b0, CTRL_OFFS, 32'h0);
    chk("ctrl kept", rd, 32'hf);
    wrap_up();
  end
endmodule : halt_standby_control_test
